/* File: rtl/lpc_led_port_ctrl.sv */
// Top of the ten-port LED drive block: register file, PWM timebase, port drive,
// input readback and reset-pin handling.
// Assumes the serial interface presents one-cycle write/read strobes with an 8-bit
// register address; the reset pin, port pins and external clock are asynchronous.
`timescale 1ns/1ps

module lpc_led_port_ctrl #(
  parameter bit HAS_EXT_CLK = 1'b1
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Register port from serial interface
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic bus_enable,
  output logic bus_abort,
  // Pins
  input wire logic rst_pin_n,
  input wire logic ext_pwm_clock_in,
  input wire logic [lpc_pkg::LPC_NPORTS-1:0] io_port_in,
  output logic [lpc_pkg::LPC_NPORTS-1:0] io_port_out,
  output logic [lpc_pkg::LPC_NPORTS-1:0] io_port_oe_n,
  // Analog control
  output logic [lpc_pkg::LPC_NPORTS-1:0] mirror_en,
  output logic [lpc_pkg::LPC_NPORTS-1:0] full_scale,
  output logic [lpc_pkg::LPC_SINK_W-1:0] sink_level,
  output logic standby
);
  import lpc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic [1:0] rst_sync_r;
  logic [1:0] ext_sync_r;
  logic ext_prev_r;
  logic [LPC_NPORTS-1:0] in_meta_r;
  logic [LPC_NPORTS-1:0] in_sync_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rst_sync_r <= 2'h0;
      ext_sync_r <= 2'h0;
      ext_prev_r <= 1'b0;
      in_meta_r <= '0;
      in_sync_r <= '0;
    end else if (ce) begin
      rst_sync_r <= {rst_sync_r[0], rst_pin_n};
      ext_sync_r <= {ext_sync_r[0], ext_pwm_clock_in};
      ext_prev_r <= ext_sync_r[1];
      in_meta_r <= io_port_in;
      in_sync_r <= in_meta_r;
    end
  end

  wire logic pin_high = rst_sync_r[1];
  logic pin_high_prev_r;
  wire logic pin_fall = pin_high_prev_r && !pin_high;
  wire logic pin_rise = !pin_high_prev_r && pin_high;

  //////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [7:0] port_code_r [LPC_NPORTS];
  logic [7:0] cfg_r;
  logic [7:0] port_scale_select_low_r;
  logic [7:0] port_scale_select_high_r;
  logic [7:0] global_sink_level_r;

  wire logic [7:0] cfg_por = HAS_EXT_CLK ? (LPC_RST_CFG | 8'h80) : LPC_RST_CFG;
  wire logic wr_ok = reg_wr && pin_high;
  wire logic por_restore = pin_fall && cfg_r[LPC_CFG_RSTPOR];
  wire logic run_restart = pin_rise && cfg_r[LPC_CFG_RSTRUN];
  wire logic wr_port = wr_ok && (reg_addr <= LPC_OFF_PORT9);
  wire logic wr_cfg = wr_ok && (reg_addr == LPC_OFF_CFG);
  wire logic [7:0] cfg_wval = HAS_EXT_CLK ? reg_wdata : {1'b0, reg_wdata[6:0]};
  wire logic [3:0] wr_idx = reg_addr[3:0];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_high_prev_r <= 1'b0;
    end else if (ce) begin
      pin_high_prev_r <= pin_high;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || (ce && por_restore)) begin
      for (int i = 0; i < LPC_NPORTS; i++) begin
        port_code_r[i] <= LPC_RST_PORT;
      end
    end else if (ce && wr_port) begin
      port_code_r[wr_idx] <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg_r <= LPC_RST_CFG | (HAS_EXT_CLK ? 8'h80 : 8'h00);
    end else if (ce) begin
      if (por_restore) begin
        cfg_r <= cfg_por;
      end else if (wr_cfg) begin
        cfg_r <= cfg_wval;
      end else if (run_restart) begin
        cfg_r[LPC_CFG_RUN] <= 1'b1;
      end
    end
  end

  // Input-level addresses fall through here, so writes to them store nothing
  always_ff @(posedge clk) begin
    if (!resetn || (ce && por_restore)) begin
      port_scale_select_low_r <= LPC_RST_SCALE;
      port_scale_select_high_r <= LPC_RST_SCALE;
      global_sink_level_r <= LPC_RST_SINK_LEVEL;
    end else if (ce && wr_ok) begin
      if (reg_addr == LPC_OFF_SCALE_LOW) begin
        port_scale_select_low_r <= reg_wdata;
      end
      if (reg_addr == LPC_OFF_SCALE_HIGH) begin
        port_scale_select_high_r <= reg_wdata;
      end
      if (reg_addr == LPC_OFF_SINK_LEVEL) begin
        global_sink_level_r <= reg_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // PWM timebase
  logic [LPC_DIV_W-1:0] div_r;
  logic [7:0] pwm_count_r;
  wire logic int_tick = (div_r == LPC_DIV_W'(LPC_INT_DIV - 1));
  wire logic ext_tick = ext_sync_r[1] && !ext_prev_r;
  wire logic pwm_tick = cfg_r[LPC_CFG_EXTCLK] ? ext_tick : int_tick;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_r <= '0;
      pwm_count_r <= 8'h00;
    end else if (ce) begin
      div_r <= int_tick ? '0 : div_r + 1'b1;
      if (pwm_tick) begin
        pwm_count_r <= pwm_count_r + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Port drive
  wire logic run = cfg_r[LPC_CFG_RUN];
  wire logic [LPC_NPORTS-1:0] sink_on;
  wire logic [LPC_NPORTS-1:0] pin_low;
  wire logic [LPC_NPORTS-1:0] is_input;
  wire logic [LPC_NPORTS-1:0] is_active;
  wire logic [15:0] scale_all = {port_scale_select_high_r, port_scale_select_low_r};

  for (genvar g = 0; g < LPC_NPORTS; g++) begin : g_port
    wire logic [7:0] phase = cfg_r[LPC_CFG_STAGGER] ? 8'((g % LPC_PHASES) * LPC_STAGGER_STEP) : 8'h00;
    lpc_port_drive u_drive (
      .code(port_code_r[g]),
      .phase(phase),
      .count(pwm_count_r),
      .run(run),
      .sink_on(sink_on[g]),
      .pin_low(pin_low[g]),
      .is_input(is_input[g])
    );
    assign is_active[g] = (port_code_r[g] != LPC_CODE_LOW) && (port_code_r[g] != LPC_CODE_HIGH)
                          && (port_code_r[g] != LPC_CODE_OFF);
  end

  wire logic [LPC_NPORTS-1:0] in_levels = in_sync_r & is_input;

  //////////////////////////////////////////////////////////////////////////////
  // Read mux
  wire logic [7:0] port_rd = (reg_addr <= LPC_OFF_PORT9) ? port_code_r[wr_idx] : 8'h00;
  wire logic [7:0] rd_val =
    (reg_addr <= LPC_OFF_PORT9) ? port_rd :
    (reg_addr == LPC_OFF_IN_LOW) ? in_levels[7:0] :
    (reg_addr == LPC_OFF_IN_HIGH) ? {6'h00, in_levels[9:8]} :
    (reg_addr == LPC_OFF_CFG) ? cfg_r :
    (reg_addr == LPC_OFF_SCALE_LOW) ? port_scale_select_low_r :
    (reg_addr == LPC_OFF_SCALE_HIGH) ? port_scale_select_high_r :
    (reg_addr == LPC_OFF_SINK_LEVEL) ? global_sink_level_r : 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
      bus_enable <= 1'b0;
      bus_abort <= 1'b0;
      io_port_out <= '0;
      io_port_oe_n <= '1;
      mirror_en <= '0;
      full_scale <= '0;
      sink_level <= LPC_RST_SINK_LEVEL[LPC_SINK_W-1:0];
      standby <= 1'b1;
    end else if (ce) begin
      if (reg_rd && pin_high) begin
        reg_rdata <= rd_val;
      end
      bus_enable <= pin_high;
      bus_abort <= pin_fall;
      io_port_out <= '0;
      io_port_oe_n <= ~pin_low;
      mirror_en <= sink_on;
      full_scale <= scale_all[LPC_NPORTS-1:0];
      sink_level <= global_sink_level_r[LPC_SINK_W-1:0];
      standby <= ~|is_active;
    end
  end
endmodule : lpc_led_port_ctrl

/* File: rtl/lpc_pkg.sv */
// Package for the ten-port LED drive block: register offsets, field positions,
// reset values, port codes and timing constants.
// Assumes a register write/read port supplied by the serial interface logic.
package lpc_pkg;
  localparam int LPC_NPORTS = 10;
  localparam int LPC_PHASES = 8;
  // Register offsets
  localparam logic [7:0] LPC_OFF_PORT0 = 8'h00;
  localparam logic [7:0] LPC_OFF_PORT9 = 8'h09;
  localparam logic [7:0] LPC_OFF_IN_LOW = 8'h0e;
  localparam logic [7:0] LPC_OFF_IN_HIGH = 8'h0f;
  localparam logic [7:0] LPC_OFF_CFG = 8'h10;
  localparam logic [7:0] LPC_OFF_SCALE_LOW = 8'h13;
  localparam logic [7:0] LPC_OFF_SCALE_HIGH = 8'h14;
  localparam logic [7:0] LPC_OFF_SINK_LEVEL = 8'h15;
  // Configuration field positions
  localparam int LPC_CFG_EXTCLK = 7;
  localparam int LPC_CFG_RSTPOR = 6;
  localparam int LPC_CFG_STAGGER = 5;
  localparam int LPC_CFG_RSTRUN = 1;
  localparam int LPC_CFG_RUN = 0;
  localparam int LPC_SINK_W = 3;
  // Reset values
  localparam logic [7:0] LPC_RST_PORT = 8'hff;
  localparam logic [7:0] LPC_RST_CFG = 8'h00;
  localparam logic [7:0] LPC_RST_SCALE = 8'h00;
  localparam logic [7:0] LPC_RST_SINK_LEVEL = 8'h07;
  // Port codes
  localparam logic [7:0] LPC_CODE_LOW = 8'h00;
  localparam logic [7:0] LPC_CODE_HIGH = 8'h01;
  localparam logic [7:0] LPC_CODE_STATIC = 8'h02;
  localparam logic [7:0] LPC_CODE_OFF = 8'hff;
  // PWM timing
  localparam int LPC_PWM_STEPS = 256;
  localparam logic [7:0] LPC_STAGGER_STEP = 8'h20;
  localparam real LPC_INT_OSC_HZ = 32000.0;
  localparam real LPC_CLK_HZ = 100000000.0;
  localparam int LPC_INT_DIV = int'(LPC_CLK_HZ / LPC_INT_OSC_HZ);
  localparam int LPC_DIV_W = 12;
endpackage : lpc_pkg

/* File: rtl/lpc_port_drive.sv */
// One port's drive decode: PWM comparison, mirror gating and pin control.
// Assumes a shared 8-bit period count and a phase offset given per port.
`timescale 1ns/1ps
module lpc_port_drive (
  // Configuration
  input wire logic [7:0] code,
  input wire logic [7:0] phase,
  input wire logic [7:0] count,
  input wire logic run,
  // Drive
  output logic sink_on,
  output logic pin_low,
  output logic is_input
);
  import lpc_pkg::*;
  wire logic [7:0] local_count = 8'(count + phase);
  wire logic is_logic_low = (code == LPC_CODE_LOW);
  wire logic is_static = (code == LPC_CODE_STATIC);
  wire logic is_pwm = (code > LPC_CODE_STATIC) && (code != LPC_CODE_OFF);
  wire logic pwm_on = local_count < code;
  assign sink_on = run && (is_static || (is_pwm && pwm_on));
  assign pin_low = is_logic_low || sink_on;
  assign is_input = (code == LPC_CODE_HIGH);
endmodule : lpc_port_drive

/* File: verif/lpc_asserts.sv */
// Port checker for the LED drive block.
// Bound to every instance of the block top; sees its ports only.
`timescale 1ns/1ps
module lpc_asserts (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Register port and pins
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic bus_enable,
  input wire logic bus_abort,
  input wire logic rst_pin_n,
  // Drive outputs
  input wire logic [lpc_pkg::LPC_NPORTS-1:0] mirror_en,
  input wire logic [lpc_pkg::LPC_NPORTS-1:0] full_scale,
  input wire logic [lpc_pkg::LPC_SINK_W-1:0] sink_level,
  input wire logic standby
);
  import lpc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Write that the block must accept: pin high long enough to be synchronised
  sequence s_wr(logic [7:0] a);
    ce && reg_wr && reg_addr == a && bus_enable && rst_pin_n && $past(rst_pin_n) && $past(rst_pin_n, 2);
  endsequence
  property p_abort_pulse; bus_abort |=> !bus_abort; endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort pulse too long");
  property p_abort_fell; $fell(bus_enable) |-> bus_abort; endproperty
  a_abort_fell: assert property (p_abort_fell) else $error("interface dropped without abort");
  property p_pin_off; !rst_pin_n [*4] |-> !bus_enable; endproperty
  a_pin_off: assert property (p_pin_off) else $error("interface live while pin low");
  property p_sink; s_wr(LPC_OFF_SINK_LEVEL) |-> ##2 sink_level == $past(reg_wdata[2:0], 2); endproperty
  a_sink: assert property (p_sink) else $error("sink level not taken");
  property p_scale_lo; s_wr(LPC_OFF_SCALE_LOW) |-> ##2 full_scale[7:0] == $past(reg_wdata, 2); endproperty
  a_scale_lo: assert property (p_scale_lo) else $error("low scale not taken");
  property p_scale_hi; s_wr(LPC_OFF_SCALE_HIGH) |-> ##2 full_scale[9:8] == $past(reg_wdata[1:0], 2); endproperty
  a_scale_hi: assert property (p_scale_hi) else $error("high scale not taken");
  property p_in_ro; s_wr(LPC_OFF_IN_HIGH) |-> ##2 $stable(full_scale) && $stable(sink_level); endproperty
  a_in_ro: assert property (p_in_ro) else $error("input register write had effect");
  property p_standby; standby [*3] |-> mirror_en == '0; endproperty
  a_standby: assert property (p_standby) else $error("mirror on in standby");
  c_abort: cover property (bus_abort);
  c_pwm: cover property (mirror_en != '0);
  c_wake: cover property (standby ##1 !standby);
endmodule : lpc_asserts

bind lpc_led_port_ctrl lpc_asserts i_chk (.clk(clk), .resetn(resetn), .ce(ce), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .bus_enable(bus_enable), .bus_abort(bus_abort),
  .rst_pin_n(rst_pin_n), .mirror_en(mirror_en), .full_scale(full_scale), .sink_level(sink_level),
  .standby(standby));

/* File: verif/lpc_host_model.sv */
// Host model: one-cycle register writes and reads.
// Drives at the falling clock edge; after the strobe, write data or read address is inverted.
`timescale 1ns/1ps
module lpc_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge clk);
    q = reg_rdata;
  endtask : rd
endmodule : lpc_host_model

/* File: verif/lpc_led_port_ctrl_tb.sv */
// Self-checking bench for the LED drive block with the host model.
// External PWM clock runs at 160 ns, 16 clocks per PWM step.
`timescale 1ns/1ps
module lpc_led_port_ctrl_tb;
  import lpc_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic rst_pin_n = 1'b1;
  logic ext_clk = 1'b0;
  logic [9:0] pins = '0;
  logic [9:0] oe_n;
  wire logic [9:0] pin_lvl = pins & oe_n;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] rdata;
  logic [7:0] q;
  logic [7:0] v;
  logic bus_enable;
  logic bus_abort;
  logic standby;
  logic [9:0] mirror_en;
  logic [9:0] full_scale;
  logic [2:0] sink_level;
  int err_total = 0;
  int num_checks = 0;
  int seed = 32'ha237;
  logic ce = 1'b1;
  int ab;
  int on0;
  int diff;
  always #5 clk = ~clk;
  always #80 ext_clk = ~ext_clk;
  lpc_host_model i_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(rdata));
  lpc_led_port_ctrl i_dut (.clk(clk), .resetn(resetn), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata), .bus_enable(bus_enable),
    .bus_abort(bus_abort), .rst_pin_n(rst_pin_n), .ext_pwm_clock_in(ext_clk), .io_port_in(pin_lvl),
    .io_port_out(), .io_port_oe_n(oe_n), .mirror_en(mirror_en), .full_scale(full_scale),
    .sink_level(sink_level), .standby(standby));
  ////////////////////////////////////////
  task automatic report_and_stop;
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, q);
    chk($sformatf("reg_%h", a), e, q);
  endtask : rchk
  task automatic wait_en;
    int i;
    for (i = 0; i < 20 && bus_enable !== 1'b1; i++) @(negedge clk);
    if (i == 20) begin
      err_total++;
      report_and_stop();
    end
  endtask : wait_en
  // One full PWM period: on time of port a, mismatch between ports a and b
  task automatic meas(input int a, input int b);
    on0 = 0;
    diff = 0;
    repeat (64) @(negedge clk);
    repeat (4096) begin
      @(negedge clk);
      on0 += (mirror_en[a] === 1'b1);
      diff += (mirror_en[a] !== mirror_en[b]);
    end
  endtask : meas
  ////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    wait_en();
    chk("standby", 1, standby);
    rchk(LPC_OFF_CFG, 8'h80);
    rchk(8'h30, 8'h00);
    repeat (8) begin
      v = 8'($random(seed));
      i_host.wr(LPC_OFF_SINK_LEVEL, v);
      i_host.wr(LPC_OFF_SCALE_LOW, ~v);
      i_host.wr(LPC_OFF_SCALE_HIGH, v ^ 8'h5a);
      @(negedge clk);
      chk("sink_level", v[2:0], sink_level);
      chk("full_scale", {v[1:0] ^ 2'b10, ~v}, full_scale);
    end
    // Clock enable low freezes state: this write must not land
    ce = 1'b0;
    i_host.wr(LPC_OFF_SINK_LEVEL, ~v);
    ce = 1'b1;
    repeat (2) @(negedge clk);
    chk("sink_level_ce", v[2:0], sink_level);
    for (int p = 0; p < 10; p++) i_host.wr(8'(p), p[0] ? LPC_CODE_LOW : LPC_CODE_HIGH);
    pins = 10'($random(seed));
    repeat (4) @(negedge clk);
    rchk(LPC_OFF_IN_LOW, pins[7:0] & 8'h55);
    i_host.wr(LPC_OFF_IN_HIGH, 8'hff);
    rchk(LPC_OFF_IN_HIGH, {6'h00, pins[9:8] & 2'b01});
    chk("standby", 1, standby);
    i_host.wr(LPC_OFF_PORT0, LPC_CODE_STATIC);
    repeat (4) @(negedge clk);
    chk("mirror_en", 0, mirror_en);
    chk("standby", 0, standby);
    i_host.wr(LPC_OFF_CFG, 8'h81);
    repeat (4) @(negedge clk);
    chk("mirror_en", 1, mirror_en);
    i_host.wr(LPC_OFF_CFG, 8'h80);
    i_host.wr(8'h00, 8'h40);
    i_host.wr(8'h01, 8'h40);
    i_host.wr(8'h02, 8'hfe);
    i_host.wr(8'h03, 8'h03);
    i_host.wr(LPC_OFF_CFG, 8'h81);
    meas(0, 1);
    chk("duty_40", 1024, on0);
    chk("in_phase", 0, diff);
    meas(2, 3);
    chk("duty_fe", 4064, on0);
    meas(3, 2);
    chk("duty_03", 48, on0);
    i_host.wr(LPC_OFF_CFG, 8'h80);
    i_host.wr(LPC_OFF_CFG, 8'ha0);
    i_host.wr(LPC_OFF_CFG, 8'ha1);
    meas(0, 1);
    chk("stagger", 1024, diff);
    i_host.wr(LPC_OFF_CFG, 8'h82);
    rst_pin_n = 1'b0;
    ab = 0;
    repeat (4) begin
      @(negedge clk);
      ab += (bus_abort === 1'b1);
    end
    chk("bus_abort", 1, ab);
    chk("bus_enable", 0, bus_enable);
    i_host.wr(LPC_OFF_SINK_LEVEL, 8'h02);
    rst_pin_n = 1'b1;
    wait_en();
    rchk(LPC_OFF_CFG, 8'h83);
    chk("sink_level", v[2:0], sink_level);
    i_host.wr(LPC_OFF_CFG, 8'h40);
    rst_pin_n = 1'b0;
    repeat (6) @(negedge clk);
    chk("sink_level", 3'h7, sink_level);
    rst_pin_n = 1'b1;
    wait_en();
    rchk(LPC_OFF_CFG, 8'h80);
    report_and_stop();
  end
endmodule : lpc_led_port_ctrl_tb
